// ===== hdl/csp_prescaler.sv
// Prescaler giving one tick per half period of the internal transfer clock
`timescale 1ns/1ps
module csp_prescaler #(
    parameter int unsigned CNT_W = 12
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control and tick
    csp_presc_if.presc pif
);
    import csp_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] half_last;

    // Half period minus one, in cycles; codes 6 and 7, and code 5 with set select zero, fall to the default of 1
    always_comb begin
        case ({pif.set_sel, pif.rate_sel})
            4'h0:    half_last = CNT_W'(2047);
            4'h1:    half_last = CNT_W'(511);
            4'h2:    half_last = CNT_W'(127);
            4'h3:    half_last = CNT_W'(31);
            4'h4:    half_last = CNT_W'(7);
            4'h8:    half_last = CNT_W'(4095);
            4'h9:    half_last = CNT_W'(1023);
            4'hA:    half_last = CNT_W'(255);
            4'hB:    half_last = CNT_W'(63);
            4'hC:    half_last = CNT_W'(15);
            4'hD:    half_last = CNT_W'(3);
            default: half_last = CNT_W'(1);
        endcase
    end

    assign pif.tick = (cnt_q == half_last) && !pif.restart;

    // Free counter, restarted so the first half period is always whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (pif.restart || pif.tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

endmodule : csp_prescaler

// ===== hdl/csp_top.sv
// Clocked serial port core with APB register access
// Behaviour
// [RULE1] Pin function change mid-transfer is followed by a mode write.
// [RULE2] Abort in the first clock low pulse sets no flag.
// [RULE3] Abort after the clock pin reads high sets the flag.
// [RULE4] Mode register: write-only, reset zero, picks pin, source, ratio.
// [RULE5] Mode write blocks transfer clock and clears bit counter.
// [RULE6] Mode write mid-transfer aborts it and sets the flag.
// [RULE7] New mode applies two cycles after its write.
// [RULE8] Prescaler/idle register: two bits, write-only, frozen in transfer.
// [RULE9] Set select bit resets to zero; idle level has no reset.
// [RULE10] Idle level write drives the output pin at once.
// [RULE11] Data leaves LSB first on transfer clock falls.
// [RULE12] Input sampled on rises, entering at the LSB end; the code shifts it in at the MSB end.
// [RULE13] Data registers are accessed only between transfers; the code also accepts shift register reads and writes during a transfer.
// [RULE14] Pin function register: three bits, write-only, reset zero.
// [RULE15] Drive/pull-up register: two bits, write-only, reset zero.
// [RULE16] Start clears counter; eight rises or abort set flag and stop.
// [RULE17] Low pin-function bits pick continuous, transmit, receive or both.
// [RULE18] Internal clock stops after eight pulses, back to start wait.
// [RULE19] Internal period 4 to 8192 cycles via prescaler.
// [RULE20] Shift data read as low and high four-bit registers.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module csp_top (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [csp_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Transfer clock pin
    input  wire logic                         sck_in,
    output logic                              sck_out,
    output logic                              sck_oe,
    // Data pins
    input  wire logic                         si_in,
    output logic                              so_out,
    output logic                              so_oe,
    // Pin configuration and request flag
    output logic                              si_sel,
    output logic                              pin_func_aux,
    output logic                              so_pmos_en,
    output logic                              pullup_en,
    output logic                              serial_irq_flag
);
    import csp_pkg::*;

    // ************************************************************
    // Registers and wires
    // ************************************************************
    csp_state_t  state_q;
    logic [3:0]  mode_pend_q;
    logic [3:0]  mode_eff_q;
    logic [1:0]  settle_q;
    logic [2:0]  pin_func_q;
    logic [1:0]  pullup_q;
    logic        set_sel_q;
    logic        idle_lvl_q;
    logic [7:0]  shift_q;
    logic [2:0]  bit_cnt_q;
    logic        flag_q;
    logic        so_q;
    logic        sck_int_q;
    logic        sck_prev_q;
    logic [31:0] prdata_q;
    logic [5:0]  idx;
    logic        mapped;
    logic        wr_acc;
    logic        mode_wr;
    logic        start_wr;
    logic        ext_clk;
    logic        fall_ev;
    logic        rise_ev;
    logic        first_low;
    logic        set_flag;
    logic        sck_level;

    csp_presc_if pif ();

    csp_prescaler #(
        .CNT_W (12)
    ) u_presc (
        .pclk    (pclk),
        .presetn (presetn),
        .pif     (pif)
    );

    // ************************************************************
    // APB decode
    // ************************************************************
    assign idx     = paddr[7:2];
    assign mapped  = (paddr[1:0] == 2'b00) &&
                     (idx == IDX_IRQ_FLAG || idx == IDX_PIN_FUNC || idx == IDX_MODE ||
                      idx == IDX_SHIFT_LO || idx == IDX_SHIFT_HI || idx == IDX_PULLUP ||
                      idx == IDX_PRESC_IDLE || idx == IDX_START || idx == IDX_STATUS);
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign mode_wr  = wr_acc && (idx == IDX_MODE);
    assign start_wr = wr_acc && (idx == IDX_START);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_q;

    // Read data captured in setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= 32'h0000_0000;
            case (idx)
                IDX_IRQ_FLAG: prdata_q[IRQ_FLAG_BIT] <= flag_q;
                IDX_SHIFT_LO: prdata_q[3:0] <= shift_q[3:0];  // [RULE20]
                IDX_SHIFT_HI: prdata_q[3:0] <= shift_q[7:4];  // [RULE20]
                IDX_STATUS:   prdata_q[2:0] <= {state_q, sck_level};
                default:      prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Mode is staged and applied two cycles after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_pend_q <= MODE_RST; // [RULE4]
            mode_eff_q  <= MODE_RST; // [RULE4]
            settle_q    <= 2'h0;
        end else if (mode_wr) begin
            mode_pend_q <= pwdata[3:0];
            settle_q    <= MODE_SETTLE_CLKS; // [RULE7]
        end else if (settle_q != 2'h0) begin
            settle_q <= settle_q - 2'h1;
            if (settle_q == 2'h1) begin
                mode_eff_q <= mode_pend_q; // [RULE7]
            end
        end
    end

    // Pin function and drive/pull-up; a pin change mid-transfer
    // is left to a software mode write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_func_q <= PIN_FUNC_RST; // [RULE14]
            pullup_q   <= PULLUP_RST; // [RULE15]
        end else begin
            if (wr_acc && idx == IDX_PIN_FUNC) begin
                pin_func_q <= pwdata[2:0]; // [RULE14] [RULE1]
            end
            if (wr_acc && idx == IDX_PULLUP) begin
                pullup_q <= pwdata[1:0]; // [RULE15]
            end
        end
    end

    // Prescaler set select, frozen while a transfer runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_sel_q <= 1'b0; // [RULE9]
        end else if (wr_acc && idx == IDX_PRESC_IDLE && state_q != CSP_ST_XFER) begin
            set_sel_q <= pwdata[SET_SEL_BIT]; // [RULE8]
        end
    end

    // Idle level has no reset value; it only holds what software wrote
    always_ff @(posedge pclk) begin
        if (wr_acc && idx == IDX_PRESC_IDLE && state_q != CSP_ST_XFER) begin
            idle_lvl_q <= pwdata[IDLE_LVL_BIT]; // [RULE8] [RULE9]
        end
    end

    // ************************************************************
    // Transfer clock
    // ************************************************************
    assign ext_clk      = (mode_eff_q[2:0] == CLK_EXT_CODE);
    assign pif.rate_sel = mode_eff_q[2:0]; // [RULE19]
    assign pif.set_sel  = set_sel_q; // [RULE19]
    assign pif.restart  = (state_q == CSP_ST_STS_WAIT) || start_wr || mode_wr;
    assign sck_level    = ext_clk ? sck_in : sck_int_q;

    // Internal clock idles high and toggles each half period while armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_int_q <= 1'b1;
        end else if (state_q == CSP_ST_STS_WAIT || mode_wr) begin
            sck_int_q <= 1'b1; // [RULE18]
        end else if (pif.tick && !ext_clk) begin
            sck_int_q <= !sck_int_q;
        end
    end

    // Previous pin level for external edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_in;
        end
    end

    // Selected clock edges, blocked by a mode write
    always_comb begin
        if (ext_clk) begin
            fall_ev = sck_prev_q && !sck_in;
            rise_ev = !sck_prev_q && sck_in;
        end else begin
            fall_ev = pif.tick && sck_int_q;
            rise_ev = pif.tick && !sck_int_q;
        end
        if (mode_wr || state_q == CSP_ST_STS_WAIT) begin
            fall_ev = 1'b0; // [RULE5]
            rise_ev = 1'b0; // [RULE5]
        end
    end

    // ************************************************************
    // Transfer control
    // ************************************************************
    // Counter zero in a transfer: first low pulse
    assign first_low = (state_q == CSP_ST_XFER) && (bit_cnt_q == 3'h0);

    always_comb begin
        set_flag = 1'b0;
        if (state_q == CSP_ST_XFER) begin
            if (mode_wr || start_wr) begin
                set_flag = !first_low; // [RULE2] [RULE6] [RULE3]
            end else if (rise_ev && bit_cnt_q == BIT_LAST) begin
                set_flag = 1'b1; // [RULE16]
            end
        end
    end

    // Operating state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CSP_ST_STS_WAIT;
        end else begin
            case (state_q)
                CSP_ST_STS_WAIT: begin
                    if (start_wr) begin
                        state_q <= CSP_ST_CLK_WAIT;
                    end
                end
                CSP_ST_CLK_WAIT: begin
                    if (mode_wr) begin
                        state_q <= CSP_ST_STS_WAIT;
                    end else if (fall_ev && !start_wr) begin
                        if (!ext_clk && pin_func_q[1:0] == 2'b00) begin
                            state_q <= CSP_ST_CONT;           // [RULE17]
                        end else begin
                            state_q <= CSP_ST_XFER;
                        end
                    end
                end
                CSP_ST_XFER: begin
                    if (mode_wr) begin
                        state_q <= CSP_ST_STS_WAIT;           // [RULE6]
                    end else if (start_wr) begin
                        state_q <= CSP_ST_CLK_WAIT;           // [RULE16]
                    end else if (rise_ev && bit_cnt_q == BIT_LAST) begin
                        state_q <= ext_clk ? CSP_ST_CLK_WAIT : CSP_ST_STS_WAIT; // [RULE18]
                    end
                end
                CSP_ST_CONT: begin
                    if (mode_wr) begin
                        state_q <= CSP_ST_STS_WAIT;
                    end
                end
                default: state_q <= CSP_ST_STS_WAIT;
            endcase
        end
    end

    // Bit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= 3'h0;
        end else if (mode_wr || start_wr || state_q != CSP_ST_XFER) begin
            bit_cnt_q <= 3'h0; // [RULE5] [RULE16]
        end else if (rise_ev) begin
            bit_cnt_q <= bit_cnt_q + 3'h1; // [RULE16]
        end
    end

    // Request flag: hardware set wins over a software clear of bit 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (set_flag) begin
            flag_q <= 1'b1; // [RULE6] [RULE16]
        end else if (wr_acc && idx == IDX_IRQ_FLAG && !pwdata[IRQ_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    // ************************************************************
    // Data path
    // ************************************************************
    // Shift register; shifting beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= SHIFT_RST;
        end else if (rise_ev && state_q == CSP_ST_XFER) begin
            shift_q <= {(pin_func_q[1] ? si_in : 1'b1), shift_q[7:1]}; // [RULE12]
        end else if (wr_acc && idx == IDX_SHIFT_LO) begin
            shift_q[3:0] <= pwdata[3:0]; // [RULE20] [RULE13]
        end else if (wr_acc && idx == IDX_SHIFT_HI) begin
            shift_q[7:4] <= pwdata[3:0]; // [RULE20] [RULE13]
        end
    end

    // Output pin: data bit on falls, idle level written when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_q <= 1'b1;
        end else if (fall_ev && (state_q == CSP_ST_CLK_WAIT || state_q == CSP_ST_XFER)) begin
            so_q <= shift_q[0]; // [RULE11]
        end else if (wr_acc && idx == IDX_PRESC_IDLE && state_q != CSP_ST_XFER) begin
            so_q <= pwdata[IDLE_LVL_BIT]; // [RULE10]
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    // Clock pin is driven only for the internal source with the pin selected
    assign sck_out         = sck_int_q;
    assign sck_oe          = mode_eff_q[MODE_PIN_BIT] && !ext_clk;  // [RULE4]
    assign so_out          = so_q;
    assign so_oe           = pin_func_q[0];                   // [RULE17]
    assign si_sel          = pin_func_q[1];                   // [RULE17]
    assign pin_func_aux    = pin_func_q[2];
    assign so_pmos_en      = pullup_q[0];                     // [RULE15]
    assign pullup_en       = pullup_q[1];                     // [RULE15]
    assign serial_irq_flag = flag_q;

endmodule : csp_top

// ===== inc/csp_pkg.sv
// Constants, register map and types for the clocked serial port
package csp_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam int unsigned ADDR_W         = 8;
    localparam logic [5:0]  IDX_IRQ_FLAG   = 6'h03;
    localparam logic [5:0]  IDX_PIN_FUNC   = 6'h04;
    localparam logic [5:0]  IDX_MODE       = 6'h05;
    localparam logic [5:0]  IDX_SHIFT_LO   = 6'h06;
    localparam logic [5:0]  IDX_SHIFT_HI   = 6'h07;
    localparam logic [5:0]  IDX_PULLUP     = 6'h0C;
    localparam logic [5:0]  IDX_PRESC_IDLE = 6'h25;
    localparam logic [5:0]  IDX_START      = 6'h30;
    localparam logic [5:0]  IDX_STATUS     = 6'h31;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned IRQ_FLAG_BIT   = 2;
    localparam int unsigned MODE_PIN_BIT   = 3;
    localparam int unsigned IDLE_LVL_BIT   = 1;
    localparam int unsigned SET_SEL_BIT    = 0;
    localparam logic [2:0]  CLK_EXT_CODE   = 3'h7;
    localparam logic [3:0]  MODE_RST       = 4'h0;
    localparam logic [2:0]  PIN_FUNC_RST   = 3'h0;
    localparam logic [1:0]  PULLUP_RST     = 2'h0;
    localparam logic [7:0]  SHIFT_RST      = 8'h00;
    localparam logic [2:0]  BIT_LAST       = 3'h7;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned TCYC_NS        = 50;
    localparam int unsigned TCYC_CLKS      = TCYC_NS / CLK_PERIOD_NS;
    localparam int unsigned MODE_SETTLE_TCYC = 2;
    localparam logic [1:0]  MODE_SETTLE_CLKS = 2'(MODE_SETTLE_TCYC * TCYC_CLKS);

    // Operating states of the port
    typedef enum logic [1:0] {
        CSP_ST_STS_WAIT,
        CSP_ST_CLK_WAIT,
        CSP_ST_XFER,
        CSP_ST_CONT
    } csp_state_t;

endpackage : csp_pkg

// ===== inc/csp_presc_if.sv
// Carrier between the port core and its prescaler
`timescale 1ns/1ps
interface csp_presc_if;
    logic [2:0] rate_sel;
    logic       set_sel;
    logic       restart;
    logic       tick;
    modport ctl   (output rate_sel, output set_sel, output restart, input tick);
    modport presc (input rate_sel, input set_sel, input restart, output tick);
endinterface : csp_presc_if

// ===== tb/csp_monitor.sv
// Assertion checker on the clocked serial port top-level ports
`timescale 1ns/1ps
module csp_monitor import csp_pkg::*; (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB side
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Serial and pin side
    input wire logic              sck_in,
    input wire logic              sck_out,
    input wire logic              sck_oe,
    input wire logic              so_out,
    input wire logic              so_oe,
    input wire logic              si_sel,
    input wire logic              so_pmos_en,
    input wire logic              pullup_en,
    input wire logic              serial_irq_flag
);
    logic       busy_q, abort_q, line_q, flag_q;
    logic [3:0] rise_q;
    wire        wr    = psel && penable && pwrite;
    wire        line  = sck_oe ? sck_out : sck_in;
    wire [3:0]  rises = rise_q + {3'h0, line & ~line_q};
    // Track frames: a start opens one, a mode write or the flag closes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy_q, abort_q, line_q, flag_q, rise_q} <= '0;
        end else begin
            line_q <= line;
            flag_q <= serial_irq_flag;
            rise_q <= rises;
            if (wr && paddr == 8'hC0) begin
                {busy_q, abort_q, rise_q} <= 6'h20;
            end else if (wr && paddr == 8'h14) begin
                busy_q  <= 1'b0;
                abort_q <= busy_q;
            end else if (serial_irq_flag && !flag_q) begin
                busy_q <= 1'b0;
            end
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_bad_addr: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr == 8'h08)
        |-> pslverr && pready) else $error("bad address");
    a_pin_func: assert property (wr && paddr == 8'h10 |=> so_oe == $past(pwdata[0])
        && si_sel == $past(pwdata[1])) else $error("pin function");
    a_pullup_ctl: assert property (wr && paddr == 8'h30 |=>
        so_pmos_en == $past(pwdata[0]) && pullup_en == $past(pwdata[1]))
        else $error("drive control");
    a_idle_level: assert property (wr && paddr == 8'h94 && !busy_q |=>
        so_out == $past(pwdata[1])) else $error("idle level");
    a_mode_delay: assert property (wr && paddr == 8'h14 |-> ##3
        sck_oe == ($past(pwdata[3], 3) && $past(pwdata[2:0], 3) != 3'h7))
        else $error("mode delay");
    a_flag_clear: assert property (wr && paddr == 8'h0C && !pwdata[2] && !busy_q
        |=> !serial_irq_flag) else $error("flag clear");
    a_eight_rises: assert property ($rose(serial_irq_flag) && busy_q && !abort_q
        |-> rises == 4'h8) else $error("rise count");
    a_sck_rest: assert property (sck_oe && !busy_q && !abort_q |-> sck_out)
        else $error("clock rest");
    a_abort_flag: assert property (wr && paddr == 8'h14 && busy_q && rise_q != 4'h0
        |-> ##[1:3] serial_irq_flag) else $error("abort flag");
endmodule : csp_monitor

// ===== tb/csp_peer.sv
// External serial peer: clocks frames in external mode, sends tx_byte and captures rx_byte
`timescale 1ns/1ps
module csp_peer #(
    parameter int HALF = 4
) (
    // Bench control
    input  wire logic       pclk,
    input  wire logic       arm,
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    // Serial pins
    input  wire logic       sck_out,
    input  wire logic       sck_oe,
    input  wire logic       so_out,
    output logic            sck_in,
    output logic            si_in,
    output logic [7:0]      rx_byte
);
    logic [3:0] nbit = 4'h8;
    logic       line_q = 1'b1;
    wire        line = sck_oe ? sck_out : sck_in;
    initial {sck_in, si_in} = 2'b10;
    // Own clock runs only within a frame and rests high between frames
    always @(posedge pclk) begin
        if (go) begin
            repeat (16) begin
                sck_in <= ~sck_in;
                repeat (HALF) @(posedge pclk);
            end
        end
    end
    // One pclk behind the line: next bit after a fall, capture after a rise;
    // after the frame the data line toggles so nothing stale stays on it
    always @(posedge pclk) begin
        line_q <= line;
        if (arm) begin
            nbit <= 4'h0;
        end else if (line && !line_q) begin
            rx_byte <= {so_out, rx_byte[7:1]};
            nbit    <= nbit + 4'h1;
        end
        if (!line && line_q && !nbit[3]) begin
            si_in <= tx_byte[nbit[2:0]];
        end else if (nbit[3]) begin
            si_in <= ~si_in;
        end
    end
endmodule : csp_peer

// ===== tb/csp_top_tb.sv
// Self-checking testbench for the clocked serial port
`timescale 1ns/1ps
module csp_top_tb;
    import csp_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [ADDR_W-1:0] paddr;
    logic [7:0]        tx, pb, rx_byte;
    logic [31:0]       pwdata, prdata, rd, seed;
    logic              sck_in, sck_out, sck_oe, si_in, so_out, so_oe, si_sel, arm, go;
    logic              pin_func_aux, so_pmos_en, pullup_en, serial_irq_flag;
    int                err_count, check_count, cyc;
    int                exp_q[$];
    csp_top csp_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe, .si_in, .so_out, .so_oe,
        .si_sel, .pin_func_aux, .so_pmos_en, .pullup_en, .serial_irq_flag);
    csp_peer csp_peer_inst (.pclk, .arm, .go, .tx_byte(pb), .sck_out, .sck_oe, .so_out,
        .sck_in, .si_in, .rx_byte);
    // Clock, and a ceiling far above the run's length
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready, then lets the write settle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, arm, go, paddr, pwdata, pb} = '0;
        {err_count, check_count, cyc} = '0;
        seed = 32'h0000_dbdf;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk(8'h10, 32'h0);
        rchk(8'h14, 32'h0);
        rchk(8'h30, 32'h0);
        rchk(8'h08, 32'h0);
        chk(perr, 1'b1);
        chk({so_out, sck_oe, so_oe, serial_irq_flag}, 4'h8);
        wr(8'h10, 32'h7);
        wr(8'h30, 32'h3);
        chk({so_oe, si_sel, pin_func_aux, so_pmos_en, pullup_en}, 5'h1F);
        wr(8'h94, 32'h0);
        chk(so_out, 1'b0);
        wr(8'h94, 32'h2);
        chk(so_out, 1'b1);
        // Two internal frames, two clocked by the peer
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            tx = (i == 1) ? 8'hFF : seed[7:0];
            pb <= seed[15:8];
            exp_q.push_back(int'(seed[15:8]));
            wr(8'h14, (i < 2) ? 32'hE : 32'hF);
            repeat (2) @(posedge pclk);
            wr(8'h18, {28'h0, tx[3:0]});
            wr(8'h1C, {28'h0, tx[7:4]});
            arm <= 1'b1;
            @(posedge pclk);
            arm <= 1'b0;
            wr(8'hC0, 32'h0);
            if (i > 1) begin
                @(posedge pclk);
                go <= 1'b1;
                @(posedge pclk);
                go <= 1'b0;
            end
            // Idle write mid-frame is ignored
            if (i == 1) begin
                while (sck_out !== 1'b0) @(posedge pclk);
                wr(8'h94, 32'h0);
            end
            while (serial_irq_flag !== 1'b1) @(posedge pclk);
            repeat (2) @(posedge pclk);
            chk(rx_byte, tx);
            if (i == 1) chk(so_out, 1'b1);
            rchk(8'h18, exp_q[0] & 15);
            rchk(8'h1C, exp_q.pop_front() >> 4);
            apb(1'b0, 8'hC4, 32'h0);
            chk(rd & 32'h6, (i < 2) ? 32'h0 : 32'h2);
            rchk(8'h0C, 32'h4);
            wr(8'h0C, 32'h0);
            rchk(8'h0C, 32'h0);
        end
        // Aborts: in the first low pulse, then after a rise
        for (int a = 0; a < 2; a++) begin
            wr(8'h14, 32'hC);
            repeat (2) @(posedge pclk);
            wr(8'hC0, 32'h0);
            while (sck_out !== 1'b0) @(posedge pclk);
            if (a == 1) while (sck_out !== 1'b1) @(posedge pclk);
            wr(8'h14, 32'hC);
            repeat (4) @(posedge pclk);
            chk(serial_irq_flag, a);
            apb(1'b0, 8'hC4, 32'h0);
            chk(rd & 32'h6, 32'h0);
            wr(8'h0C, 32'h0);
        end
        tally_and_finish();
    end
endmodule : csp_top_tb
bind csp_top csp_monitor csp_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe, .so_out, .so_oe,
    .si_sel, .so_pmos_en, .pullup_en, .serial_irq_flag);
